// ### hdl/bus_port_group_io_cfg.svh
`ifndef BUS_PORT_GROUP_IO_CFG_SVH
`define BUS_PORT_GROUP_IO_CFG_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PORT_ADDR_W        8
`define PORT_DATA_W        8
`define OFS_A_DATA         8'h18
`define OFS_B_DATA         8'h19
`define OFS_C_DATA         8'h1a
`define OFS_A_DIRECTION    8'h20
`define OFS_B_DIRECTION    8'h21
`define OFS_C_DIRECTION    8'h22
`define OFS_A_ALT_SELECT   8'h28
`define OFS_B_ALT_SELECT   8'h29
`define OFS_C_ALT_SELECT   8'h2a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CLEAR          8'h00
`define RST_A_EXT_BUS      8'hff
`define RST_B_EXT_BUS      8'hff
`define RST_C_EXT_BUS      8'h0f
`define READ_UNMAPPED      8'h00

`endif

// ### hdl/bus_port_group_io_pkg.sv
package bus_port_group_io_pkg;

   `include "bus_port_group_io_cfg.svh"

   typedef logic [`PORT_DATA_W-1:0] byte_t;
   typedef logic [`PORT_ADDR_W-1:0] addr_t;

   // One-hot register select
   typedef enum logic [9:0] {
      SEL_NONE    = 10'h001,
      SEL_A_DATA  = 10'h002,
      SEL_A_DIR   = 10'h004,
      SEL_A_ALT   = 10'h008,
      SEL_B_DATA  = 10'h010,
      SEL_B_DIR   = 10'h020,
      SEL_B_ALT   = 10'h040,
      SEL_C_DATA  = 10'h080,
      SEL_C_DIR   = 10'h100,
      SEL_C_ALT   = 10'h200
   } reg_sel_e;

endpackage : bus_port_group_io_pkg

// ### hdl/bus_port_group_io.sv
// Behaviour
// - Internal-fetch reset: port A direction, alt select and data all zero.
// - External-fetch reset: port A direction and alt select all ones, data zero.
// - Internal-fetch reset: port B direction, alt select and data all zero.
// - External-fetch reset: port B direction and alt select all ones, data zero.
// - Internal-fetch reset: port C direction, alt select and data all zero.
// - External-fetch reset: port C low four bits ones, data zero.
// - Pin reset, break, watchdog overflow and opcode trap reset ports alike.
// - Data read gives pin when direction 0, data register when 1.
// - Read-modify-write reads by same selection, writes result to data register.
// - Port B is 8 bits, each bit's direction set independently.
// - Direction 1, alt off: pin driven from data register bit.
// - Port B direction 1, alt 1: pin driven from bus address.
// - Port B direction 0, alt 1: pull-up on; alt 0: no pull-up.
// - Port C is 4 bits, per-bit direction, output from data register.
// - Port C bits without pins have no storage and read zero.
// - Port C direction 1, alt 1: pin driven from bus address.
// - Port C direction 0, alt 1: pull-up on.
// - Port A alt mode carries bus data, or data plus multiplexed address.
// - Port A bit serves bus only with direction 1 and alt 1.
`timescale 1ns/100ps

module bus_port_group_io
   import bus_port_group_io_pkg::*;
#(
   parameter int PORT_A_WIDTH = 8,
   parameter int PORT_B_WIDTH = 8,
   parameter int PORT_C_WIDTH = 4
) (
   input  wire logic                           core_clk,
   input  wire logic                           srst,
   input  wire logic                           external_reset_pin_n,
   input  wire logic                           break_instruction,
   input  wire logic                           watchdog_overflow,
   input  wire logic                           opcode_trap,
   input  wire logic                           external_access_pin_n,
   input  wire bus_port_group_io_pkg::addr_t   reg_addr,
   input  wire bus_port_group_io_pkg::byte_t   reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output bus_port_group_io_pkg::byte_t        reg_rdata,
   output logic                                reg_rvalid,
   input  wire logic [PORT_A_WIDTH-1:0]        port_a_pin_in,
   output logic      [PORT_A_WIDTH-1:0]        port_a_pin_out,
   output logic      [PORT_A_WIDTH-1:0]        port_a_pin_oe,
   output logic      [PORT_A_WIDTH-1:0]        port_a_pull_up,
   input  wire logic [PORT_A_WIDTH-1:0]        bus_data_out,
   input  wire logic                           bus_data_oe,
   output logic      [PORT_A_WIDTH-1:0]        bus_data_in,
   input  wire logic [PORT_B_WIDTH-1:0]        port_b_pin_in,
   output logic      [PORT_B_WIDTH-1:0]        port_b_pin_out,
   output logic      [PORT_B_WIDTH-1:0]        port_b_pin_oe,
   output logic      [PORT_B_WIDTH-1:0]        port_b_pull_up,
   input  wire logic [PORT_B_WIDTH-1:0]        bus_addr_b,
   input  wire logic [PORT_C_WIDTH-1:0]        port_c_pin_in,
   output logic      [PORT_C_WIDTH-1:0]        port_c_pin_out,
   output logic      [PORT_C_WIDTH-1:0]        port_c_pin_oe,
   output logic      [PORT_C_WIDTH-1:0]        port_c_pull_up,
   input  wire logic [PORT_C_WIDTH-1:0]        bus_addr_c
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (PORT_A_WIDTH != `PORT_DATA_W || PORT_B_WIDTH != `PORT_DATA_W) begin : g_chk_ab
      $error("ports A and B must be one register byte wide");
   end
   if (PORT_C_WIDTH < 1 || PORT_C_WIDTH > `PORT_DATA_W) begin : g_chk_c
      $error("port C width must be 1 to 8");
   end

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic reg_sel_e decode(input addr_t a);
      reg_sel_e s;
      s = SEL_NONE;
      if (a == `OFS_A_DATA) begin
         s = SEL_A_DATA;
      end else if (a == `OFS_A_DIRECTION) begin
         s = SEL_A_DIR;
      end else if (a == `OFS_A_ALT_SELECT) begin
         s = SEL_A_ALT;
      end else if (a == `OFS_B_DATA) begin
         s = SEL_B_DATA;
      end else if (a == `OFS_B_DIRECTION) begin
         s = SEL_B_DIR;
      end else if (a == `OFS_B_ALT_SELECT) begin
         s = SEL_B_ALT;
      end else if (a == `OFS_C_DATA) begin
         s = SEL_C_DATA;
      end else if (a == `OFS_C_DIRECTION) begin
         s = SEL_C_DIR;
      end else if (a == `OFS_C_ALT_SELECT) begin
         s = SEL_C_ALT;
      end
      return s;
   endfunction : decode

   // Per bit: pin when input, latch when output; alt select plays no part
   function automatic byte_t port_view(input byte_t dir, input byte_t data,
                                       input byte_t pin);
      return (dir & data) | (~dir & pin);
   endfunction : port_view

   // ----------------------------------------
   // Reset and decode
   // ----------------------------------------
   logic      port_reset;
   logic      ext_fetch;
   reg_sel_e  wr_sel;
   reg_sel_e  rd_sel;
   byte_t     c_rst_bus;

   // Every cause lands on the same port reset
   assign port_reset = srst | ~external_reset_pin_n | break_instruction
                       | watchdog_overflow | opcode_trap;
   // External fetch mode when the access pin is held low
   assign ext_fetch  = ~external_access_pin_n;
   assign wr_sel     = reg_wr ? decode(reg_addr) : SEL_NONE;
   assign rd_sel     = reg_rd ? decode(reg_addr) : SEL_NONE;
   assign c_rst_bus  = `RST_C_EXT_BUS;

   // ----------------------------------------
   // Write enables
   // ----------------------------------------
   // One enable per register keeps each always_ff to its own concern
   logic we_a_data;
   logic we_a_dir;
   logic we_a_alt;
   logic we_b_data;
   logic we_b_dir;
   logic we_b_alt;
   logic we_c_data;
   logic we_c_dir;
   logic we_c_alt;

   assign we_a_data = (wr_sel == SEL_A_DATA);
   assign we_a_dir  = (wr_sel == SEL_A_DIR);
   assign we_a_alt  = (wr_sel == SEL_A_ALT);
   assign we_b_data = (wr_sel == SEL_B_DATA);
   assign we_b_dir  = (wr_sel == SEL_B_DIR);
   assign we_b_alt  = (wr_sel == SEL_B_ALT);
   assign we_c_data = (wr_sel == SEL_C_DATA);
   assign we_c_dir  = (wr_sel == SEL_C_DIR);
   assign we_c_alt  = (wr_sel == SEL_C_ALT);

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   // Access pin is looked at only while a reset cause is active
   byte_t a_rst_value;
   byte_t b_rst_value;

   assign a_rst_value = ext_fetch ? `RST_A_EXT_BUS : `RST_CLEAR;
   assign b_rst_value = ext_fetch ? `RST_B_EXT_BUS : `RST_CLEAR;

   // ----------------------------------------
   // Port A registers
   // ----------------------------------------
   byte_t a_data_reg;
   byte_t a_dir_reg;
   byte_t a_alt_reg;

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         a_data_reg <= `RST_CLEAR;
      end else if (we_a_data) begin
         a_data_reg <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         a_dir_reg <= a_rst_value;
      end else if (we_a_dir) begin
         a_dir_reg <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         a_alt_reg <= a_rst_value;
      end else if (we_a_alt) begin
         a_alt_reg <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Port B registers
   // ----------------------------------------
   byte_t b_data_reg;
   byte_t b_dir_reg;
   byte_t b_alt_reg;

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         b_data_reg <= `RST_CLEAR;
      end else if (we_b_data) begin
         b_data_reg <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         b_dir_reg <= b_rst_value;
      end else if (we_b_dir) begin
         b_dir_reg <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         b_alt_reg <= b_rst_value;
      end else if (we_b_alt) begin
         b_alt_reg <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Port C registers
   // ----------------------------------------
   // Only pinned bits are stored; upper bits are never built
   logic [PORT_C_WIDTH-1:0] c_data_reg;
   logic [PORT_C_WIDTH-1:0] c_dir_reg;
   logic [PORT_C_WIDTH-1:0] c_alt_reg;
   logic [PORT_C_WIDTH-1:0] c_rst_value;

   assign c_rst_value = ext_fetch ? c_rst_bus[PORT_C_WIDTH-1:0]
                                  : {PORT_C_WIDTH{1'b0}};

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         c_data_reg <= {PORT_C_WIDTH{1'b0}};
      end else if (we_c_data) begin
         c_data_reg <= reg_wdata[PORT_C_WIDTH-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         c_dir_reg <= c_rst_value;
      end else if (we_c_dir) begin
         c_dir_reg <= reg_wdata[PORT_C_WIDTH-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (port_reset) begin
         c_alt_reg <= c_rst_value;
      end else if (we_c_alt) begin
         c_alt_reg <= reg_wdata[PORT_C_WIDTH-1:0];
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   byte_t c_data_wide;
   byte_t c_dir_wide;
   byte_t c_alt_wide;
   byte_t c_pin_wide;
   byte_t rdata_next;
   byte_t a_view;
   byte_t b_view;
   byte_t c_view;

   // Missing bits read as zero
   assign c_data_wide = byte_t'(c_data_reg);
   assign c_dir_wide  = byte_t'(c_dir_reg);
   assign c_alt_wide  = byte_t'(c_alt_reg);
   assign c_pin_wide  = byte_t'(port_c_pin_in);

   // Same view feeds plain reads and read-modify-write sources
   assign a_view = port_view(a_dir_reg, a_data_reg, port_a_pin_in);
   assign b_view = port_view(b_dir_reg, b_data_reg, port_b_pin_in);
   assign c_view = port_view(c_dir_wide, c_data_wide, c_pin_wide);

   always_comb begin
      rdata_next = `READ_UNMAPPED;
      case (rd_sel)
         SEL_A_DATA: rdata_next = a_view;
         SEL_A_DIR:  rdata_next = a_dir_reg;
         SEL_A_ALT:  rdata_next = a_alt_reg;
         SEL_B_DATA: rdata_next = b_view;
         SEL_B_DIR:  rdata_next = b_dir_reg;
         SEL_B_ALT:  rdata_next = b_alt_reg;
         SEL_C_DATA: rdata_next = c_view;
         SEL_C_DIR:  rdata_next = c_dir_wide;
         SEL_C_ALT:  rdata_next = c_alt_wide;
         default:    rdata_next = `READ_UNMAPPED;
      endcase
   end

   // Data stands for the one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= `READ_UNMAPPED;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Bus controller samples port A pins directly; no extra latency on reads
   assign bus_data_in = port_a_pin_in;

   for (genvar i = 0; i < PORT_A_WIDTH; i++) begin : g_pin_a
      logic bus_bit;
      assign bus_bit = a_dir_reg[i] & a_alt_reg[i];
      // Bus mode: controller owns both direction and value
      assign port_a_pin_oe[i]  = bus_bit ? bus_data_oe : a_dir_reg[i];
      assign port_a_pin_out[i] = bus_bit ? bus_data_out[i] : a_data_reg[i];
      assign port_a_pull_up[i] = ~a_dir_reg[i] & a_alt_reg[i];
   end

   for (genvar i = 0; i < PORT_B_WIDTH; i++) begin : g_pin_b
      assign port_b_pin_oe[i]  = b_dir_reg[i];
      assign port_b_pin_out[i] = b_alt_reg[i] ? bus_addr_b[i] : b_data_reg[i];
      assign port_b_pull_up[i] = ~b_dir_reg[i] & b_alt_reg[i];
   end

   for (genvar i = 0; i < PORT_C_WIDTH; i++) begin : g_pin_c
      assign port_c_pin_oe[i]  = c_dir_reg[i];
      assign port_c_pin_out[i] = c_alt_reg[i] ? bus_addr_c[i] : c_data_reg[i];
      assign port_c_pull_up[i] = ~c_dir_reg[i] & c_alt_reg[i];
   end

endmodule : bus_port_group_io

// ### sim/bus_port_group_io_checker.sv
`timescale 1ns/100ps
`include "bus_port_group_io_cfg.svh"
module bus_port_group_io_checker
   import bus_port_group_io_pkg::*;
#(
   parameter int PORT_A_WIDTH = 8,
   parameter int PORT_B_WIDTH = 8,
   parameter int PORT_C_WIDTH = 4
) (
   input wire logic                         core_clk,
   input wire logic                         srst,
   input wire logic                         external_reset_pin_n,
   input wire logic                         break_instruction,
   input wire logic                         watchdog_overflow,
   input wire logic                         opcode_trap,
   input wire logic                         external_access_pin_n,
   input wire bus_port_group_io_pkg::addr_t reg_addr,
   input wire logic                         reg_rd,
   input wire bus_port_group_io_pkg::byte_t reg_rdata,
   input wire logic                         reg_rvalid,
   input wire logic [PORT_A_WIDTH-1:0]      port_a_pin_out,
   input wire logic [PORT_A_WIDTH-1:0]      port_a_pin_oe,
   input wire logic [PORT_A_WIDTH-1:0]      port_a_pull_up,
   input wire logic [PORT_A_WIDTH-1:0]      bus_data_out,
   input wire logic                         bus_data_oe,
   input wire logic [PORT_B_WIDTH-1:0]      port_b_pin_out,
   input wire logic [PORT_B_WIDTH-1:0]      port_b_pin_oe,
   input wire logic [PORT_B_WIDTH-1:0]      port_b_pull_up,
   input wire logic [PORT_B_WIDTH-1:0]      bus_addr_b,
   input wire logic [PORT_C_WIDTH-1:0]      port_c_pin_out,
   input wire logic [PORT_C_WIDTH-1:0]      port_c_pin_oe,
   input wire logic [PORT_C_WIDTH-1:0]      port_c_pull_up,
   input wire logic [PORT_C_WIDTH-1:0]      bus_addr_c
);
   import bus_port_group_io_pkg::*;
   logic any_rst;
   // Causes other than srst, so the disable does not mask them
   assign any_rst = !external_reset_pin_n || break_instruction || watchdog_overflow || opcode_trap;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_RST_A_INT: assert property (any_rst && external_access_pin_n |=>
      port_a_pin_oe == '0 && port_a_pull_up == '0) else $error("port A not input after reset");
   AST_RST_A_EXT: assert property (any_rst && !external_access_pin_n |=>
      port_a_pin_oe == {PORT_A_WIDTH{bus_data_oe}} && port_a_pin_out == bus_data_out)
      else $error("port A not bus after reset");
   AST_RST_B_EXT: assert property (any_rst && !external_access_pin_n |=>
      port_b_pin_oe == '1 && port_b_pin_out == bus_addr_b) else $error("port B not address");
   AST_RST_C_EXT: assert property (any_rst && !external_access_pin_n |=>
      port_c_pin_oe == '1 && port_c_pin_out == bus_addr_c) else $error("port C not address");
   AST_RST_BC_INT: assert property (any_rst && external_access_pin_n |=>
      port_b_pin_oe == '0 && port_c_pin_oe == '0 && port_c_pull_up == '0)
      else $error("port B or C not input after reset");
   AST_PULL_ONLY_IN: assert property ((port_a_pull_up & port_a_pin_oe) == '0 &&
      (port_b_pull_up & port_b_pin_oe) == '0 && (port_c_pull_up & port_c_pin_oe) == '0)
      else $error("pull-up on a driven pin");
   AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid || !$past(reg_rd, 1)))
      else $error("read answer not one cycle later");
   AST_READ_IDLE: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   AST_C_UPPER_ZERO: assert property (reg_rd && reg_addr inside {`OFS_C_DATA, `OFS_C_DIRECTION,
      `OFS_C_ALT_SELECT} |=> reg_rdata[7:4] == 4'h0) else $error("port C upper bits set");
endmodule : bus_port_group_io_checker

// ### sim/bus_pins_model.sv
`timescale 1ns/100ps
module bus_pins_model (
   input  wire logic [7:0] port_a_pin_out,
   input  wire logic [7:0] port_a_pin_oe,
   input  wire logic [7:0] port_a_pull_up,
   input  wire logic [7:0] port_b_pin_out,
   input  wire logic [7:0] port_b_pin_oe,
   input  wire logic [7:0] port_b_pull_up,
   input  wire logic [3:0] port_c_pin_out,
   input  wire logic [3:0] port_c_pin_oe,
   input  wire logic [3:0] port_c_pull_up,
   input  wire logic [7:0] ext_a,
   input  wire logic [7:0] ext_b,
   input  wire logic [3:0] ext_c,
   output logic      [7:0] port_a_pin_in,
   output logic      [7:0] port_b_pin_in,
   output logic      [3:0] port_c_pin_in
);
   // Driven bit wins; an undriven pulled bit reads high, else the board level
   assign port_a_pin_in = port_a_pin_oe & port_a_pin_out | ~port_a_pin_oe & (port_a_pull_up | ext_a);
   assign port_b_pin_in = port_b_pin_oe & port_b_pin_out | ~port_b_pin_oe & (port_b_pull_up | ext_b);
   assign port_c_pin_in = port_c_pin_oe & port_c_pin_out | ~port_c_pin_oe & (port_c_pull_up | ext_c);
endmodule : bus_pins_model

// ### sim/bus_port_group_io_tb.sv
`timescale 1ns/100ps
`include "bus_port_group_io_cfg.svh"
module bus_port_group_io_tb;
   import bus_port_group_io_pkg::*;
   logic core_clk, srst = 1, external_reset_pin_n = 1, break_instruction = 0;
   logic watchdog_overflow = 0, opcode_trap = 0, external_access_pin_n = 1;
   logic reg_wr = 0, reg_rd = 0, reg_rvalid, bus_data_oe = 1;
   addr_t reg_addr = 8'h00;
   byte_t reg_wdata = 8'h00, reg_rdata, got, bus_data_in, bus_data_out = 8'h5a, bus_addr_b = 8'h69;
   byte_t port_a_pin_in, port_a_pin_out, port_a_pin_oe, port_a_pull_up, ext_a = 8'h00;
   byte_t port_b_pin_in, port_b_pin_out, port_b_pin_oe, port_b_pull_up, ext_b = 8'h00;
   logic [3:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_c_pull_up, ext_c = 4'h0;
   logic [3:0] bus_addr_c = 4'h9;
   logic [71:0] r;
   logic [23:0] o;
   int n_mismatch = 0, comparisons = 0, cyc = 0;
   // Columns: port, dir, alt, data, board, read, oe, pull-up, driven bits
   logic [71:0] rows [5] = '{72'h01_f0_cc_a5_30_ac_f0_0c_60, 72'h01_ff_00_5a_00_5a_ff_00_5a,
      72'h01_00_00_00_a5_a5_00_00_00, 72'h00_0f_3c_96_c3_f6_0f_30_0a,
      72'h02_f5_f6_fd_00_07_05_02_01};
   addr_t addrs [9] = '{8'h20, 8'h21, 8'h22, 8'h28, 8'h29, 8'h2a, 8'h18, 8'h19, 8'h1a};
   bus_port_group_io bus_port_group_io_inst (.core_clk, .srst, .external_reset_pin_n,
      .break_instruction, .watchdog_overflow, .opcode_trap, .external_access_pin_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .port_a_pin_in, .port_a_pin_out,
      .port_a_pin_oe, .port_a_pull_up, .bus_data_out, .bus_data_oe, .bus_data_in, .port_b_pin_in,
      .port_b_pin_out, .port_b_pin_oe, .port_b_pull_up, .bus_addr_b, .port_c_pin_in,
      .port_c_pin_out, .port_c_pin_oe, .port_c_pull_up, .bus_addr_c);
   bus_pins_model bus_pins_model_inst (.port_a_pin_out, .port_a_pin_oe, .port_a_pull_up,
      .port_b_pin_out, .port_b_pin_oe, .port_b_pull_up, .port_c_pin_out, .port_c_pin_oe,
      .port_c_pull_up, .ext_a, .ext_b, .ext_c, .port_a_pin_in, .port_b_pin_in, .port_c_pin_in);
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Called at a rising edge; returns at the edge that closes the answer cycle
   task automatic acc(input logic w, input addr_t a, input byte_t d, output byte_t q);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge core_clk);
      q = reg_rdata;
   endtask : acc
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         r = rows[i];
         ext_a <= r[39:32];
         ext_b <= r[39:32];
         ext_c <= r[35:32];
         acc(1, 8'h20 + r[71:64], r[63:56], got);
         acc(1, 8'h28 + r[71:64], r[55:48], got);
         acc(1, 8'h18 + r[71:64], r[47:40], got);
         acc(0, 8'h18 + r[71:64], 8'h00, got);
         chk({16'h0, got}, {16'h0, r[31:24]});
         case (r[65:64])
            2'd0: o = {port_a_pin_oe, port_a_pull_up, port_a_pin_out & port_a_pin_oe};
            2'd1: o = {port_b_pin_oe, port_b_pull_up, port_b_pin_out & port_b_pin_oe};
            default: o = {4'h0, port_c_pin_oe, 4'h0, port_c_pull_up, 4'h0, port_c_pin_out & port_c_pin_oe};
         endcase
         chk(o, r[23:0]);
      end
      for (int c = 0; c < 10; c++) begin
         external_access_pin_n <= c[0];
         ext_a <= 8'h3c;
         ext_b <= 8'hc5;
         ext_c <= 4'h6;
         case (c >> 1)
            0: srst <= 1'b1;
            1: external_reset_pin_n <= 1'b0;
            2: break_instruction <= 1'b1;
            3: watchdog_overflow <= 1'b1;
            default: opcode_trap <= 1'b1;
         endcase
         @(posedge core_clk);
         {srst, break_instruction, watchdog_overflow, opcode_trap} <= 4'h0;
         external_reset_pin_n <= 1'b1;
         for (int k = 0; k < 9; k++) begin
            acc(0, addrs[k], 8'h00, got);
            if (k < 6) chk({16'h0, got}, (c[0] || k % 3 == 2) ? (c[0] ? 0 : 24'h0f) : 24'hff);
            else chk({16'h0, got}, c[0] ? (k == 6 ? 24'h3c : k == 7 ? 24'hc5 : 24'h06) : 0);
         end
      end
      ext_b <= 8'hc0;
      acc(1, `OFS_B_DIRECTION, 8'h0f, got);
      acc(1, `OFS_B_DATA, 8'h03, got);
      acc(0, `OFS_B_DATA, 8'h00, got);
      chk({16'h0, got}, 24'hc3);
      acc(1, `OFS_B_DATA, got ^ 8'h11, got);
      acc(1, `OFS_B_DIRECTION, 8'hff, got);
      acc(0, `OFS_B_DATA, 8'h00, got);
      chk({8'h0, got, port_b_pin_out}, 24'h00d2d2);
      acc(0, 8'h30, 8'h00, got);
      chk({16'h0, got}, 24'h0);
      acc(1, `OFS_A_DIRECTION, 8'hff, got);
      acc(1, `OFS_A_ALT_SELECT, 8'hff, got);
      ext_a <= 8'h7e;
      bus_data_oe <= 1'b0;
      @(posedge core_clk);
      chk({port_a_pin_oe, bus_data_in, port_a_pull_up}, 24'h007e00);
      bus_data_oe <= 1'b1;
      @(posedge core_clk);
      chk({port_a_pin_oe, port_a_pin_out, bus_data_in}, 24'hff5a5a);
      test_done();
   end
endmodule : bus_port_group_io_tb
bind bus_port_group_io bus_port_group_io_checker #(.PORT_A_WIDTH(PORT_A_WIDTH),
   .PORT_B_WIDTH(PORT_B_WIDTH), .PORT_C_WIDTH(PORT_C_WIDTH)) bus_port_group_io_checker_inst (
   .core_clk, .srst, .external_reset_pin_n, .break_instruction, .watchdog_overflow, .opcode_trap,
   .external_access_pin_n, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .port_a_pin_out,
   .port_a_pin_oe, .port_a_pull_up, .bus_data_out, .bus_data_oe, .port_b_pin_out, .port_b_pin_oe,
   .port_b_pull_up, .bus_addr_b, .port_c_pin_out, .port_c_pin_oe, .port_c_pull_up, .bus_addr_c);
